// ---- design/sad_datapath.sv ----
// Sum-of-absolute-differences datapath for block motion search
// Notes on behaviour
// - Four independent byte-lane subtracts per step
// - Lane carry-out kept as sign flag
// - Flags expand to mask giving absolute value
// - Second subtract keeps earlier flags, shifted left four
// - Four 8-bit lane sums, overflow carries recorded
// - Each carry is worth 256; eight per pass
// - Next pass counts eight carries into total
// - Eight lane accumulations per two cycles sustained
// - Lane sums combine into a 10-bit partial
// - Result is carry count times 256 plus partial
// - Unaligned merging done by supplier, extra cycles tolerated
`timescale 1ns/10ps
module sad_datapath
    import sad_pkg::*;
(
    input  wire logic              mclk,         // 20 MHz clock
    input  wire logic              srst,         // Synchronous reset
    input  wire logic              clr,          // Start of new block
    input  wire logic              step_valid,   // Word pair offered
    input  wire logic              step_last,    // Last pair of block
    input  wire logic [WORD_W-1:0] cur_word,     // Current pixels
    input  wire logic [WORD_W-1:0] ref_word,     // Reference pixels
    output logic                   step_ready,   // Pair accepted
    output logic                   result_valid, // Result pulse
    output logic [RES_W-1:0]       result_sad    // Total difference
);
    // ****************************************
    // State
    // ****************************************
    sad_lane_if lif ();                            // Link to lane unit

    logic              take;                       // Step accepted
    sad_phase_t        phase_q, phase_d;           // Subtract phase
    logic [FLAG_W-1:0] lane_borrow_flags_q, lane_borrow_flags_d; // Sign flags
    logic [WORD_W-1:0] diff_q, diff_d;             // Stored differences
    logic              v1_q, v1_d;                 // Difference stage valid
    logic              last1_q, last1_d;           // Difference stage last
    logic              ph1_q, ph1_d;               // Difference stage phase
    logic [WORD_W-1:0] running_lane_error_sums_q, running_lane_error_sums_d; // Sums
    logic [FLAG_W-1:0] carry_flags_q, carry_flags_d; // Sum carries of pass
    logic              v2_q, v2_d;                 // Flags ready to count
    logic              last2_q, last2_d;           // Accumulate stage last
    logic [FLAG_W-1:0] carry_pattern_index_q, carry_pattern_index_d; // Count input
    logic              last3_q, last3_d;           // Counting stage last
    logic [CNT_W-1:0]  total_carry_count_q, total_carry_count_d; // Carry total
    logic              fin_q, fin_d;               // Total is final
    logic              res_v_q, res_v_d;           // Result pulse
    logic [RES_W-1:0]  res_q, res_d;               // Result value

    // Ones count of a carry pattern
    function automatic logic [NIB_W-1:0] ones(input logic [FLAG_W-1:0] p);
        logic [NIB_W-1:0] n;
        n = '0;
        for (int i = 0; i < FLAG_W; i++) begin
            n = n + {3'b000, p[i]};
        end
        return n;
    endfunction

    // ****************************************
    // Lane unit hookup
    // ****************************************
    sad_lane_alu u_alu (
        .lif (lif.alu)
    );

    assign lif.cur_word  = cur_word;
    assign lif.ref_word  = ref_word;
    assign lif.acc_diff  = diff_q;
    assign lif.acc_flags = lane_borrow_flags_q[NIB_W-1:0];
    assign lif.sums_in   = running_lane_error_sums_q;

    // A step may come any cycle except a clear cycle; gaps for word merging are harmless
    assign step_ready = !clr;
    assign take       = step_valid && !clr;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic [PART_W-1:0] partial; // Combined lane sums
        partial = '0;
        phase_d = phase_q;
        lane_borrow_flags_d = lane_borrow_flags_q;
        diff_d  = diff_q;
        v1_d    = take;
        last1_d = step_last;
        ph1_d   = phase_q;
        running_lane_error_sums_d = running_lane_error_sums_q;
        carry_flags_d = carry_flags_q;
        v2_d    = 1'b0;
        last2_d = 1'b0;
        carry_pattern_index_d = carry_pattern_index_q;
        last3_d = 1'b0;
        total_carry_count_d = total_carry_count_q;
        fin_d   = 1'b0;
        res_v_d = 1'b0;
        res_d   = res_q;
        // Subtract stage
        if (take) begin
            diff_d = lif.diff;
            if (phase_q == SAD_PH_FIRST) begin
                lane_borrow_flags_d = {4'h0, lif.borrow};
                phase_d = step_last ? SAD_PH_FIRST : SAD_PH_SECOND;
            end else begin
                // Earlier flags move up so new borrows do not overwrite them
                lane_borrow_flags_d = {lane_borrow_flags_q[NIB_W-1:0],
                                       lif.borrow};
                phase_d = SAD_PH_FIRST;
            end
        end
        // Accumulate stage, one step per cycle
        if (v1_q) begin
            running_lane_error_sums_d = lif.sums_out;
            if (ph1_q == SAD_PH_FIRST) begin
                carry_flags_d = {4'h0, lif.carries};
            end else begin
                carry_flags_d = {carry_flags_q[NIB_W-1:0], lif.carries};
            end
            // Pass end or block end hands flags to counting
            v2_d    = (ph1_q == SAD_PH_SECOND) || last1_q;
            last2_d = last1_q;
        end
        // Counting stage: flags of the previous pass
        if (v2_q) begin
            carry_pattern_index_d = carry_flags_q;
            last3_d = last2_q;
        end
        if (v2_q || last3_q) begin
            total_carry_count_d = total_carry_count_q
                                + {12'h000, ones(carry_pattern_index_q)};
        end
        fin_d = last3_q;
        // Combine stage
        if (fin_q) begin
            for (int i = 0; i < LANES; i++) begin
                partial = partial
                        + {2'b00, running_lane_error_sums_q[i*LANE_W +: LANE_W]};
            end
            res_d = {2'b00, total_carry_count_q, 8'h00}
                  + {16'h0000, partial};
            res_v_d = 1'b1;
        end
        // Clear of a new block zeroes flags, lane sums, carry count and stage valids
        if (clr) begin
            phase_d = SAD_PH_FIRST;
            lane_borrow_flags_d = FLAGS_RST;
            running_lane_error_sums_d = SUMS_RST;
            carry_flags_d = FLAGS_RST;
            carry_pattern_index_d = FLAGS_RST;
            total_carry_count_d = CNT_RST;
            v1_d = 1'b0;
            v2_d = 1'b0;
            last3_d = 1'b0;
            fin_d = 1'b0;
            res_v_d = 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            phase_q <= SAD_PH_FIRST;
            lane_borrow_flags_q <= FLAGS_RST;
            diff_q <= SUMS_RST;
            v1_q <= 1'b0;
            last1_q <= 1'b0;
            ph1_q <= 1'b0;
            running_lane_error_sums_q <= SUMS_RST;
            carry_flags_q <= FLAGS_RST;
            v2_q <= 1'b0;
            last2_q <= 1'b0;
            carry_pattern_index_q <= FLAGS_RST;
            last3_q <= 1'b0;
            total_carry_count_q <= CNT_RST;
            fin_q <= 1'b0;
            res_v_q <= 1'b0;
            res_q <= '0;
        end else begin
            phase_q <= phase_d;
            lane_borrow_flags_q <= lane_borrow_flags_d;
            diff_q <= diff_d;
            v1_q <= v1_d;
            last1_q <= last1_d;
            ph1_q <= ph1_d;
            running_lane_error_sums_q <= running_lane_error_sums_d;
            carry_flags_q <= carry_flags_d;
            v2_q <= v2_d;
            last2_q <= last2_d;
            carry_pattern_index_q <= carry_pattern_index_d;
            last3_q <= last3_d;
            total_carry_count_q <= total_carry_count_d;
            fin_q <= fin_d;
            res_v_q <= res_v_d;
            res_q <= res_d;
        end
    end

    assign result_valid = res_v_q;
    assign result_sad   = res_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_take_last;
        take && step_last;
    endsequence
    sequence s_result;
        result_valid ##1 !result_valid;
    endsequence

    property p_borrow_sign;
        take |=> lane_borrow_flags_q[0]
               == ($past(cur_word[7:0]) >= $past(ref_word[7:0]));
    endproperty
    a_borrow_sign: assert property (p_borrow_sign) else $error("lane flag wrong");
    property p_lane_split;
        take |=> diff_q[15:8] == 8'($past(cur_word[15:8]) - $past(ref_word[15:8]));
    endproperty
    a_lane_split: assert property (p_lane_split) else $error("lane diff wrong");
    property p_rotate;
        take && phase_q == SAD_PH_SECOND && !clr
            |=> lane_borrow_flags_q[7:4] == $past(lane_borrow_flags_q[3:0]);
    endproperty
    a_rotate: assert property (p_rotate) else $error("flags not kept");
    property p_abs_acc;
        v1_q && !clr && lif.carries == 4'h0 |=> running_lane_error_sums_q[7:0]
            == 8'($past(running_lane_error_sums_q[7:0])
            + ($past(lane_borrow_flags_q[0]) ? $past(diff_q[7:0])
               : 8'(8'h00 - $past(diff_q[7:0]))));
    endproperty
    a_abs_acc: assert property (p_abs_acc) else $error("lane sum wrong");
    property p_count;
        v2_q && !clr |=> total_carry_count_q
            == $past(total_carry_count_q) + 16'(ones($past(carry_pattern_index_q)));
    endproperty
    a_count: assert property (p_count) else $error("carry count wrong");
    property p_latency;
        s_take_last ##1 !clr [*5] |-> s_result;
    endproperty
    a_latency: assert property (p_latency) else $error("result late");
    property p_combine;
        fin_q && !clr |=> result_sad == {2'b00, $past(total_carry_count_q), 8'h00}
            + 26'($past(running_lane_error_sums_q[7:0]))
            + 26'($past(running_lane_error_sums_q[15:8]))
            + 26'($past(running_lane_error_sums_q[23:16]))
            + 26'($past(running_lane_error_sums_q[31:24]));
    endproperty
    a_combine: assert property (p_combine) else $error("result wrong");
    property p_clear;
        clr |=> total_carry_count_q == CNT_RST && running_lane_error_sums_q == SUMS_RST
                && !result_valid;
    endproperty
    a_clear: assert property (p_clear) else $error("clear incomplete");
    property p_throughput;
        v1_q && !clr |=> running_lane_error_sums_q == $past(lif.sums_out);
    endproperty
    a_throughput: assert property (p_throughput) else $error("step dropped");
endmodule

// ---- design/sad_lane_alu.sv ----
// Byte-lane subtract and masked absolute accumulate
`timescale 1ns/10ps
module sad_lane_alu
    import sad_pkg::*;
(
    sad_lane_if.alu lif             // Operands and results
);
    // ****************************************
    // Mask expansion
    // ****************************************
    // One flag becomes eight mask bits of its lane
    function automatic logic [WORD_W-1:0] expand_mask(input logic [NIB_W-1:0] f);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{f[i]}};
        end
        return m;
    endfunction

    logic [WORD_W-1:0] mask;        // Flag-expanded byte mask

    // ****************************************
    // Lane arithmetic
    // ****************************************
    // Each lane is independent; no carry crosses a lane boundary
    always_comb begin
        logic [LANE_W:0]   sub9;    // Lane difference with carry
        logic [LANE_W-1:0] mag;     // Lane absolute value
        logic [LANE_W:0]   add9;    // Lane sum with carry
        sub9 = '0;
        mag  = '0;
        add9 = '0;
        mask = expand_mask(lif.acc_flags);
        for (int i = 0; i < LANES; i++) begin
            // Carry out is set when current >= reference
            sub9 = {1'b1, lif.cur_word[i*LANE_W +: LANE_W]}
                 - {1'b0, lif.ref_word[i*LANE_W +: LANE_W]};
            lif.diff[i*LANE_W +: LANE_W] = sub9[LANE_W-1:0];
            lif.borrow[i] = sub9[LANE_W];
            // Mask picks add of the difference or add of its negation
            mag = (lif.acc_diff[i*LANE_W +: LANE_W] & mask[i*LANE_W +: LANE_W])
                | ((~lif.acc_diff[i*LANE_W +: LANE_W] + 8'h01)
                   & ~mask[i*LANE_W +: LANE_W]);
            add9 = {1'b0, lif.sums_in[i*LANE_W +: LANE_W]} + {1'b0, mag};
            lif.sums_out[i*LANE_W +: LANE_W] = add9[LANE_W-1:0];
            lif.carries[i] = add9[LANE_W];
        end
    end
endmodule

// ---- design/sad_lane_if.sv ----
// Carrier between the sequencer and the byte-lane arithmetic unit
`timescale 1ns/10ps
interface sad_lane_if;
    import sad_pkg::*;
    logic [WORD_W-1:0] cur_word;    // Current-frame pixels
    logic [WORD_W-1:0] ref_word;    // Reference-frame pixels
    logic [WORD_W-1:0] diff;        // Lane differences, low 8 bits each
    logic [NIB_W-1:0]  borrow;      // Lane carry-outs, 1 = current >= reference
    logic [WORD_W-1:0] acc_diff;    // Stored differences to accumulate
    logic [NIB_W-1:0]  acc_flags;   // Stored sign flags for the mask
    logic [WORD_W-1:0] sums_in;     // Running lane sums
    logic [WORD_W-1:0] sums_out;    // Updated lane sums
    logic [NIB_W-1:0]  carries;     // Lane-sum overflows

    modport ctl (output cur_word, ref_word, acc_diff, acc_flags, sums_in,
                 input diff, borrow, sums_out, carries);
    modport alu (input cur_word, ref_word, acc_diff, acc_flags, sums_in,
                 output diff, borrow, sums_out, carries);
endinterface

// ---- design/sad_pkg.sv ----
// Constants and types shared by the absolute-difference datapath
package sad_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int LANES     = 4;   // Byte lanes per word
    localparam int LANE_W    = 8;   // Pixel and lane-sum width
    localparam int WORD_W    = 32;  // Pixel word width
    localparam int FLAG_W    = 8;   // Flags held over one pass
    localparam int NIB_W     = 4;   // Flags per step
    localparam int PART_W    = 10;  // Combined lane-sum width
    localparam int CNT_W     = 16;  // Total carry count width
    localparam int CNT_SHIFT = 8;   // One carry is worth 256
    localparam int RES_W     = CNT_W + CNT_SHIFT + 2; // Result width

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00; // Flags clear
    localparam logic [WORD_W-1:0] SUMS_RST  = 32'h0000_0000; // Lane sums clear
    localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000; // Carry count clear

    // Pass phase: two subtract steps per pass
    typedef enum logic [0:0] {
        SAD_PH_FIRST  = 1'b0,       // First subtract of a pass
        SAD_PH_SECOND = 1'b1        // Second subtract of a pass
    } sad_phase_t;
endpackage

// ---- dv/sad_fetch_model.sv ----
// Pixel fetch unit model that feeds word pairs into the datapath
`timescale 1ns/10ps
module sad_fetch_model
    import sad_pkg::*;
(
    mclk,       // Datapath clock
    step_ready, // Pair accepted
    clr,        // Start of block
    step_valid, // Pair offered
    step_last,  // Last pair of block
    cur_word,   // Current pixels
    ref_word    // Reference pixels
);
    input  wire logic              mclk;
    input  wire logic              step_ready;
    output logic                   clr;
    output logic                   step_valid;
    output logic                   step_last;
    output logic [WORD_W-1:0]      cur_word;
    output logic [WORD_W-1:0]      ref_word;

    // Quiet outputs at time zero
    initial begin
        clr        = 1'b0;
        step_valid = 1'b0;
        step_last  = 1'b0;
        cur_word   = 32'h0000_0000;
        ref_word   = 32'h0000_0000;
    end

    // Released pixel lines toggle so stale data never looks valid
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            step_valid <= 1'b0;
            step_last  <= 1'b0;
            cur_word   <= ~cur_word;
            ref_word   <= ~ref_word;
            @(posedge mclk);
        end
    endtask

    // One-cycle clear ahead of each block
    task automatic clear();
        clr        <= 1'b1;
        step_valid <= 1'b0;
        @(posedge mclk);
        clr        <= 1'b0;
    endtask

    // One word pair, held until the edge that takes it
    task automatic send(input logic [WORD_W-1:0] c, input logic [WORD_W-1:0] r,
                        input logic last, input int gap);
        int n;
        idle(gap);
        step_valid <= 1'b1;
        step_last  <= last;
        cur_word   <= c;
        ref_word   <= r;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!step_ready && n < 50);
    endtask

    // Current bytes straddle two words: two extra cycles to merge
    task automatic send_split(input logic [WORD_W-1:0] lo, input logic [WORD_W-1:0] hi,
                              input logic [WORD_W-1:0] r, input int off, input logic last);
        logic [2*WORD_W-1:0] both;
        both = {hi, lo} >> (LANE_W * off);
        send(both[WORD_W-1:0], r, last, 2);
    endtask
endmodule

// ---- dv/test_sad_datapath.sv ----
// Self-checking bench for the absolute-difference datapath
`timescale 1ns/10ps
module test_sad_datapath
    import sad_pkg::*;
;
    logic              mclk;         // Clock
    logic              srst;         // Reset
    logic              clr;          // Block clear
    logic              step_valid;   // Pair offered
    logic              step_last;    // Last pair
    logic [WORD_W-1:0] cur_word;     // Current pixels
    logic [WORD_W-1:0] ref_word;     // Reference pixels
    logic              step_ready;   // Pair accepted
    logic              result_valid; // Result pulse
    logic [RES_W-1:0]  result_sad;   // Total difference
    int                bad_count;    // Mismatches
    int                check_count;  // Comparisons
    int                cyc;          // Cycle counter
    int                last_cyc;     // Edge of last take
    int                clr_cyc;      // Edge of last clear
    logic              prev_rv;      // Pulse seen last edge
    logic [RES_W-1:0]  exp_q[$];     // Expected results
    logic [WORD_W-1:0] cq[$];        // Block current words
    logic [WORD_W-1:0] rq[$];        // Block reference words

    sad_datapath i_dut (.mclk(mclk), .srst(srst), .clr(clr), .step_valid(step_valid),
        .step_last(step_last), .cur_word(cur_word), .ref_word(ref_word),
        .step_ready(step_ready), .result_valid(result_valid), .result_sad(result_sad));

    sad_fetch_model i_fetch (.mclk(mclk), .step_ready(step_ready), .clr(clr),
        .step_valid(step_valid), .step_last(step_last), .cur_word(cur_word),
        .ref_word(ref_word));

    // ****************************************
    // Helpers
    // ****************************************
    always #25 mclk = ~mclk;

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Reference sum of absolute byte differences
    function automatic int lane_sad(input logic [WORD_W-1:0] c, input logic [WORD_W-1:0] r);
        int s;
        int d;
        s = 0;
        for (int k = 0; k < LANES; k++) begin
            d = int'(c[k*LANE_W +: LANE_W]) - int'(r[k*LANE_W +: LANE_W]);
            s += (d < 0) ? -d : d;
        end
        return s;
    endfunction

    // Final report and end of run
    task automatic summarize();
        $display("Checks %0d, errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watches takes, clears and result pulses; cuts a hang short
    always @(posedge mclk) begin
        cyc++;
        if (!srst && step_valid && step_ready && step_last)
            last_cyc = cyc;
        if (!srst && clr) begin
            clr_cyc = cyc;
            check(32'(step_ready), 32'h0, "ready during clear");
        end else if (!srst) begin
            // Gapped or back-to-back steps are always accepted outside a clear
            check(32'(step_ready), 32'h1, "ready outside clear");
        end
        if (!srst && result_valid) begin
            // Pulse is sampled five edges after the edge that takes the last pair
            check(32'(cyc - last_cyc), 32'h5, "result latency");
            check(32'(prev_rv), 32'h0, "pulse length");
            if (exp_q.size() == 0)
                check(32'h1, 32'h0, "unexpected result");
            else
                check(32'(result_sad), 32'(exp_q.pop_front()), "total");
        end
        prev_rv = result_valid;
        if (cyc > 3000) begin
            bad_count++;
            summarize();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    // Whole block from the queues, then result held afterwards
    task automatic run_block(input int gap);
        int e;
        e = 0;
        for (int i = 0; i < cq.size(); i++)
            e += lane_sad(cq[i], rq[i]);
        exp_q.push_back(RES_W'(e));
        i_fetch.clear();
        for (int i = 0; i < cq.size(); i++)
            i_fetch.send(cq[i], rq[i], i == cq.size() - 1, gap);
        i_fetch.idle(8);
        check(32'(exp_q.size()), 32'h0, "result missing");
        check(32'(result_sad), 32'(e), "result held");
        cq.delete();
        rq.delete();
    endtask

    // Mixed signs per lane, one full pass
    task automatic t_mixed();
        cq = '{32'h45D01A33, 32'h33221100};
        rq = '{32'h4810F129, 32'h00112233};
        run_block(0);
    endtask

    // Largest differences, alternating sign, back to back
    task automatic t_carries();
        for (int i = 0; i < 8; i++) begin
            cq.push_back((i % 2) ? 32'h0000_0000 : 32'hFFFF_FFFF);
            rq.push_back((i % 2) ? 32'hFFFF_FFFF : 32'h0000_0000);
        end
        run_block(0);
        check(32'(last_cyc - clr_cyc), 32'h8, "step rate");
    endtask

    // No borrow across lanes, odd final step, gapped steps
    task automatic t_lanes();
        cq = '{32'h00010000, 32'h80000001, 32'h017F0000};
        rq = '{32'h00000001, 32'h7F000002, 32'h00800000};
        run_block(1);
        cq = '{32'hFFFFFFFF};
        rq = '{32'h00000000};
        run_block(0);
    endtask

    // Merged unaligned word, then a clear that cancels a pending result
    task automatic t_split_abort();
        exp_q.push_back(RES_W'(lane_sad(32'h44AABBCC, 32'h01020304) + 16));
        i_fetch.clear();
        i_fetch.send_split(32'hAABBCCDD, 32'h11223344, 32'h01020304, 1, 1'b0);
        i_fetch.send(32'h00000010, 32'h00000020, 1'b1, 0);
        i_fetch.idle(8);
        check(32'(exp_q.size()), 32'h0, "merged result");
        i_fetch.clear();
        i_fetch.send(32'h000000FF, 32'h00000000, 1'b1, 0);
        i_fetch.idle(2);
        cq = '{32'h00000009};
        rq = '{32'h00000002};
        run_block(0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        mclk        = 1'b0;
        srst        = 1'b1;
        bad_count   = 0;
        check_count = 0;
        cyc         = 0;
        last_cyc    = 0;
        clr_cyc     = 0;
        prev_rv     = 1'b0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        check(32'(result_sad), 32'h0, "reset value");
        t_mixed();
        t_carries();
        t_lanes();
        t_split_abort();
        summarize();
    end
endmodule
